// File: hdl/mplc_consts.vh
`ifndef MPLC_CONSTS_VH
`define MPLC_CONSTS_VH

// Timing figures
`define MPLC_CLK_MHZ 100
`define MPLC_DISC_MS 200
`define MPLC_DCD_WAIT_MS 35000
`define MPLC_MASK_MS 2000
`define MPLC_DISC_CYC (`MPLC_DISC_MS * 1000 * `MPLC_CLK_MHZ)
`define MPLC_DCD_WAIT_CYC (`MPLC_DCD_WAIT_MS * 1000 * `MPLC_CLK_MHZ)
`define MPLC_MASK_CYC (`MPLC_MASK_MS * 1000 * `MPLC_CLK_MHZ)

// Mode word bit positions
`define MPLC_MODE_HOT_BIT 0
`define MPLC_MODE_FDTR_BIT 1
`define MPLC_MODE_KBD_BIT 2
`define MPLC_MODE_ROLE_BIT 3

// Register offsets
`define MPLC_REG_CFG 4'h0
`define MPLC_REG_CTRL 4'h1
`define MPLC_REG_STAT 4'h2

// Config fields
`define MPLC_CFG_HOT 0
`define MPLC_CFG_FDTR 1
`define MPLC_CFG_KBD 2
`define MPLC_CFG_ROLE 3
`define MPLC_CFG_PORT_TYPE_RS422 4
`define MPLC_CFG_BAUD_LO 5
`define MPLC_CFG_RESET 8'h00

// Control fields
`define MPLC_CTRL_OUT_CALL 0
`define MPLC_CTRL_RELEASE 1

`endif

// File: hdl/mplc_top.v
`timescale 1ns/1ps
`include "mplc_consts.vh"

module mplc_top #(
    parameter [31:0] DISC_CYC = `MPLC_DISC_CYC,
    parameter [31:0] DCD_WAIT_CYC = `MPLC_DCD_WAIT_CYC,
    parameter [31:0] MASK_CYC = `MPLC_MASK_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire modem_dsr,
    input wire modem_dcd,
    input wire modem_ri,
    input wire cr_seen,
    output reg modem_dtr,
    output reg busy_out,
    output reg link_through,
    output reg prompt_en,
    output reg echo_en,
    output reg autobaud_wait,
    output reg hotline_req,
    output reg [1:0] hotline_baud
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_IN_WAIT = 3'h1;
    localparam [2:0] ST_IN_CALL = 3'h2;
    localparam [2:0] ST_OUT_CALL = 3'h3;
    localparam [2:0] ST_DISC = 3'h4;
    localparam [2:0] ST_MASK = 3'h5;

    reg [7:0] cfg_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [31:0] cnt_q;
    reg [31:0] cnt_d;
    reg out_req_q;
    reg rel_req_q;
    reg timeout_q;
    reg [3:0] mode_w;
    reg dtr_mode_w;
    reg forced_w;
    reg hot_w;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always @* begin
        if (cfg_q[`MPLC_CFG_PORT_TYPE_RS422]) begin
            mode_w = 4'h8;
        end else begin
            mode_w = {cfg_q[`MPLC_CFG_ROLE], cfg_q[`MPLC_CFG_KBD], cfg_q[`MPLC_CFG_FDTR], cfg_q[`MPLC_CFG_HOT]};
        end
        dtr_mode_w = (mode_w[3:2] == 2'h0);
        forced_w = mode_w[`MPLC_MODE_FDTR_BIT];
        hot_w = mode_w[`MPLC_MODE_HOT_BIT];
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `MPLC_CFG_RESET;
            out_req_q <= 1'b0;
            rel_req_q <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            out_req_q <= 1'b0;
            rel_req_q <= 1'b0;
            if (reg_wr && reg_addr == `MPLC_REG_CFG) begin
                cfg_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `MPLC_REG_CTRL) begin
                out_req_q <= reg_wdata[`MPLC_CTRL_OUT_CALL];
                rel_req_q <= reg_wdata[`MPLC_CTRL_RELEASE];
            end
            if (reg_rd) begin
                case (reg_addr)
                    `MPLC_REG_CFG: reg_rdata <= cfg_q;
                    `MPLC_REG_STAT: reg_rdata <= {timeout_q, modem_dtr, busy_out, 2'h0, state_q};
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Call sequencer
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (cnt_q != 32'h0) begin
            cnt_d = cnt_q - 32'h1;
        end
        case (state_q)
            ST_IDLE: begin
                if (!dtr_mode_w) begin
                    state_d = ST_IDLE;
                end else if (modem_ri) begin
                    state_d = ST_IN_WAIT;
                    cnt_d = DCD_WAIT_CYC;
                end else if (out_req_q) begin
                    state_d = ST_OUT_CALL;
                end
            end
            ST_IN_WAIT: begin
                if (modem_dcd && modem_dsr) begin
                    state_d = ST_IN_CALL;
                end else if (cnt_q == 32'h0 || rel_req_q) begin
                    state_d = ST_DISC;
                    cnt_d = DISC_CYC;
                end
            end
            ST_IN_CALL, ST_OUT_CALL: begin
                if (!modem_dsr || rel_req_q || (state_q == ST_IN_CALL && !modem_dcd)) begin
                    state_d = ST_DISC;
                    cnt_d = DISC_CYC;
                end
            end
            ST_DISC: begin
                if (cnt_q == 32'h0) begin
                    state_d = forced_w ? ST_MASK : ST_IDLE;
                    cnt_d = MASK_CYC;
                end
            end
            ST_MASK: begin
                if (cnt_q == 32'h0) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Inbound or outbound call in progress
    function call_state;
        input [2:0] st;
        begin
            call_state = (st == ST_IN_CALL) || (st == ST_OUT_CALL);
        end
    endfunction

    // One-cycle entry into the inbound call state
    function in_call_entry;
        input [2:0] st_now;
        input [2:0] st_next;
        begin
            in_call_entry = (st_now != ST_IN_CALL) && (st_next == ST_IN_CALL);
        end
    endfunction

    // DTR level that goes with the next state
    function dtr_level;
        input dtr_mode;
        input forced;
        input [2:0] st_next;
        begin
            if (!dtr_mode) begin
                dtr_level = 1'b0;
            end else if (st_next == ST_DISC) begin
                dtr_level = 1'b0;
            end else if (forced) begin
                dtr_level = 1'b1;
            end else begin
                dtr_level = (st_next == ST_IN_WAIT) || call_state(st_next);
            end
        end
    endfunction

    // ----------------------------------------
    // State and counter
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Carrier timeout flag
    // ----------------------------------------
    // Kept until the next call; software cannot clear it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_q <= 1'b0;
        end else if (state_q == ST_IN_WAIT && state_d == ST_DISC && !rel_req_q) begin
            timeout_q <= 1'b1;
        end else if (call_state(state_d)) begin
            timeout_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Terminal ready lead
    // ----------------------------------------
    // DTR level
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_dtr <= 1'b0;
        end else begin
            modem_dtr <= dtr_level(dtr_mode_w, forced_w, state_d);
        end
    end

    // ----------------------------------------
    // Busy to outbound callers
    // ----------------------------------------
    // busy to outbound
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state_d != ST_IDLE);
        end
    end

    // ----------------------------------------
    // Transparent link
    // ----------------------------------------
    // transparent path
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_through <= 1'b0;
        end else begin
            link_through <= (state_d == ST_OUT_CALL);
        end
    end

    // ----------------------------------------
    // Prompts
    // ----------------------------------------
    // prompt gating
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prompt_en <= 1'b0;
        end else begin
            prompt_en <= (state_d == ST_IN_CALL) && modem_dcd;
        end
    end

    // ----------------------------------------
    // Echo
    // ----------------------------------------
    // echo gating
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_en <= 1'b0;
        end else begin
            echo_en <= (state_d == ST_IN_CALL) && modem_dcd;
        end
    end

    // ----------------------------------------
    // Autobaud wait
    // ----------------------------------------
    // autobaud wait
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            autobaud_wait <= 1'b0;
        end else if (in_call_entry(state_q, state_d)) begin
            autobaud_wait <= 1'b1;
        end else if (cr_seen || state_d != ST_IN_CALL) begin
            autobaud_wait <= 1'b0;
        end
    end

    // ----------------------------------------
    // Hotline request
    // ----------------------------------------
    // hotline call
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hotline_req <= 1'b0;
        end else begin
            hotline_req <= hot_w && in_call_entry(state_q, state_d);
        end
    end

    // ----------------------------------------
    // Hotline baud
    // ----------------------------------------
    // hotline baud
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hotline_baud <= 2'h0;
        end else begin
            hotline_baud <= cfg_q[`MPLC_CFG_BAUD_LO+1:`MPLC_CFG_BAUD_LO];
        end
    end

endmodule // mplc_top

// File: sim/mplc_modem_model.sv
`timescale 1ns/1ps
module mplc_modem_model (
    input wire sys_clk,
    input wire ring,
    input wire hang,
    input wire [7:0] ans_dly,
    input wire modem_dtr,
    output reg modem_dsr = 1'b0,
    output reg modem_dcd = 1'b0,
    output reg modem_ri = 1'b0
);
    // --------------------------------------------
    // Modem leads; answer delay FF means no answer
    // --------------------------------------------
    reg [7:0] cnt = 8'h00;
    reg armed = 1'b0;
    always @(posedge sys_clk) begin
        modem_ri <= ring;
        modem_dsr <= !hang;
        if (!modem_dtr || hang) begin
            cnt <= 8'h00;
            armed <= 1'b0;
            modem_dcd <= 1'b0;
        end else begin
            if (ring) armed <= 1'b1;
            if (armed && cnt != ans_dly) cnt <= cnt + 8'h01;
            modem_dcd <= armed && cnt == ans_dly && ans_dly != 8'hFF;
        end
    end
endmodule // mplc_modem_model

// File: sim/mplc_top_properties.sv
`timescale 1ns/1ps
module mplc_top_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire modem_dsr,
    input wire modem_dcd,
    input wire modem_dtr,
    input wire busy_out,
    input wire link_through,
    input wire prompt_en,
    input wire echo_en,
    input wire autobaud_wait,
    input wire hotline_req
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_quiet; !modem_dcd ##1 !modem_dcd |=> !echo_en && !prompt_en; endproperty
    a_quiet: assert property (p_quiet) else $error("echo or prompt without carrier");
    property p_link; link_through |-> !prompt_en && !echo_en; endproperty
    a_link: assert property (p_link) else $error("prompt on outbound link");
    property p_call; prompt_en || link_through |-> modem_dtr && busy_out; endproperty
    a_call: assert property (p_call) else $error("call without dtr or busy");
    property p_busy; $rose(busy_out) |-> modem_dtr; endproperty
    a_busy: assert property (p_busy) else $error("busy without dtr");
    // Eight cycles is a floor, the real hold is longer
    // A mode change while idle also drops DTR; only a drop during a call is a disconnect
    property p_disc; $fell(modem_dtr) && busy_out |=> !modem_dtr [*8]; endproperty
    a_disc: assert property (p_disc) else $error("dtr drop too short");
    property p_drop; $fell(modem_dsr) && busy_out |-> ##[1:3] !prompt_en && !link_through; endproperty
    a_drop: assert property (p_drop) else $error("call kept after dsr loss");
    property p_auto; $rose(autobaud_wait) |-> $past(modem_dcd && modem_dsr); endproperty
    a_auto: assert property (p_auto) else $error("validated without carrier");
    property p_hot; hotline_req |-> busy_out ##1 !hotline_req; endproperty
    a_hot: assert property (p_hot) else $error("hotline request not a pulse");
endmodule // mplc_top_chk
bind mplc_top mplc_top_chk u_chk (.*);

// File: sim/tb_mplc_top.sv
`timescale 1ns/1ps
module tb_mplc_top;
    reg sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cr_seen = 0, ring = 0, hang = 0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00, ans_dly = 8'h03;
    reg [1:0] b;
    wire [7:0] reg_rdata;
    wire [1:0] hotline_baud;
    wire modem_dsr, modem_dcd, modem_ri, modem_dtr, busy_out, link_through, prompt_en, echo_en, autobaud_wait;
    wire hotline_req;
    integer fails = 0, n_tests = 0, seed = 32'h0d095962, m, i, h, n_hot = 0;
    // -----------------------
    // Clock, parts, utilities
    // -----------------------
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (hotline_req === 1'b1) n_hot <= n_hot + 1;
    // Short counts keep the run brief
    mplc_top #(.DISC_CYC(20), .DCD_WAIT_CYC(100), .MASK_CYC(50)) dut (.*);
    mplc_modem_model modem (.*);
    task chk(input [63:0] s, input [63:0] e, input [8*8-1:0] nm);
        n_tests = n_tests + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("BAD %0s exp %0h saw %0h", nm, e, s);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 0;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 0;
        @(negedge sys_clk) chk(reg_rdata, e, "rdata");
    endtask
    task till(input integer n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task close_out;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        close_out;
    end
    // ------------------
    // Main test sequence
    // ------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1;
        @(negedge sys_clk) chk(modem_dtr, 0, "dtr_rst");
        rd(4'hF, 8'h00);
        for (m = 0; m < 4; m = m + 1) begin
            b = $random(seed);
            ans_dly <= 8'h03 + ($random(seed) & 31);
            wr(4'h0, {1'b0, b, 3'b000, m[1:0]});
            rd(4'h0, {1'b0, b, 3'b000, m[1:0]});
            chk(hotline_baud, b, "baud");
            chk(modem_dtr, m[1], "dtr_idle");
            h = n_hot;
            @(posedge sys_clk) ring <= 1;
            for (i = 0; i < 300 && autobaud_wait !== 1'b1; i = i + 1) @(negedge sys_clk);
            chk({prompt_en, busy_out, modem_dtr, link_through}, 4'b1110, "inbound");
            @(posedge sys_clk) {ring, cr_seen} <= 2'b01;
            @(posedge sys_clk) cr_seen <= 0;
            till(2);
            chk(autobaud_wait, 0, "cr");
            chk(n_hot - h, m[0], "hotline");
            @(posedge sys_clk) hang <= 1;
            for (i = 0; i < 300 && modem_dtr !== 1'b0; i = i + 1) @(negedge sys_clk);
            chk(prompt_en | echo_en, 0, "drop");
            @(posedge sys_clk) hang <= 0;
            if (m[1]) begin
                for (i = 0; i < 300 && modem_dtr !== 1'b1; i = i + 1) @(negedge sys_clk);
                @(posedge sys_clk) ring <= 1;
                repeat (8) @(posedge sys_clk);
                ring <= 0;
            end
            for (i = 0; i < 300 && busy_out !== 1'b0; i = i + 1) @(negedge sys_clk);
            till(12);
            chk({busy_out, modem_dtr}, {1'b0, m[1]}, "idle");
            wr(4'h1, 8'h01);
            till(2);
            chk({link_through, prompt_en, modem_dtr, busy_out}, 4'b1011, "outbound");
            wr(4'h1, 8'h02);
            for (i = 0; i < 300 && busy_out !== 1'b0; i = i + 1) @(negedge sys_clk);
        end
        // Modem never answers: carrier wait runs out
        wr(4'h0, 8'h00);
        ans_dly <= 8'hFF;
        @(posedge sys_clk) ring <= 1;
        repeat (5) @(posedge sys_clk);
        ring <= 0;
        till(85);
        chk(busy_out, 1, "waiting");
        for (i = 0; i < 60 && busy_out !== 1'b0; i = i + 1) @(negedge sys_clk);
        rd(4'h2, 8'h80);
        wr(4'h0, 8'h12);
        @(posedge sys_clk) ring <= 1;
        till(10);
        chk({busy_out, modem_dtr}, 0, "rs422");
        close_out;
    end
endmodule // tb_mplc_top
